// ---- pkg/spb_regs.svh ----
// Register offsets, field positions and reset values of the store and prefetch buffers
// Summary of operation
// - Queue holds eight entries of 1-16 bytes
// - Control bit 3 enables the queue
// - Reset leaves queue disabled and empty
// - Post only when enabled and bufferable, or for a copy-back
// - Posted writes ignore external abort
// - Only store-multiple words merge
// - Cache hit stores bypass the queue
// - Bufferable misses post without core stall
// - Full queue stalls the core
// - Unbuffered store waits for empty and completion
// - Disabling keeps queued writes; drain forces out
// - Copy-backs always pass through the queue
// - Four 32-byte entries serve hitting loads
// - Allocate word, half-line or line
// - Align allocation; only fetched words valid
// - Translation miss stalls; fill runs behind
// - Faulting allocation is dropped, abort raised
// - A word lives in one entry only
// - Buffer copy wins over cache copy
// - Allocation invalidates target, ignores cache bits
// - Access to filling entry stalls
// - Aborted fill completes; later loads abort
// - Stores skip buffer; software keeps coherency
`ifndef SPB_REGS_SVH
`define SPB_REGS_SVH
`define SPB_CTRL_OFF 8'h00
`define SPB_STAT_OFF 8'h04
`define SPB_AADR_OFF 8'h08
`define SPB_ACMD_OFF 8'h0C
`define SPB_INVL_OFF 8'h10
`define SPB_DRN_OFF 8'h14
`define SPB_WQ_EN_BIT 3
`define SPB_CTRL_RST 32'h0000_0000
`define SPB_ACMD_ENT_LSB 0
`define SPB_ACMD_SZ_LSB 2
`define SPB_ST_EMPTY_BIT 0
`define SPB_ST_CNT_LSB 1
`define SPB_ST_ABT_LSB 5
`define SPB_ST_BUSY_BIT 9
`define SPB_WQ_DEPTH 8
`endif

// ---- pkg/spb_pkg.sv ----
// Types shared by the store and prefetch buffer modules
package spb_pkg;
  // Allocation sizes
  typedef enum logic [1:0] {
    SZ_WORD = 2'b00,
    SZ_HALF = 2'b01,
    SZ_LINE = 2'b10
  } spb_size_t;
  // One queued write: 16-byte line, data lanes and byte enables
  typedef struct packed {
    logic [27:0] line;
    logic [127:0] data;
    logic [15:0] be;
  } spb_wq_ent_t;
  // Request towards the memory controller
  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [127:0] wdata;
    logic [15:0] be;
  } spb_mem_req_t;
  // Allocation sequencer
  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_XL = 2'b01,
    P_FILL = 2'b10
  } spb_pf_st_t;
  // Memory port sequencer
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_WR = 2'b01,
    M_RD = 2'b10
  } spb_mem_st_t;
endpackage

// ---- rtl/spb_wq.sv ----
// Posted write queue storage: in-order ring with tail merge
`timescale 1ns/100ps
`include "spb_regs.svh"
module spb_wq
  import spb_pkg::*;
#(
  parameter int DEPTH = `SPB_WQ_DEPTH,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic merge,
  input wire spb_wq_ent_t in_ent,
  input wire logic pop,
  input wire logic head_busy,
  output logic merge_ok,
  output logic full,
  output logic empty,
  output logic [AW:0] count,
  output spb_wq_ent_t head
);
  // Entry storage; data needs no reset, count says what is live
  spb_wq_ent_t ent_q [DEPTH];
  logic [AW-1:0] rd_q, wr_q, tail;
  logic [AW:0] cnt_q;

  // Byte enables widened to a bit mask over the sixteen byte lanes
  function automatic logic [127:0] lane_mask(logic [15:0] be);
    for (int b = 0; b < 16; b++)
      lane_mask[8*b +: 8] = {8{be[b]}};
  endfunction

  assign tail = wr_q - 1'b1;
  assign count = cnt_q;
  assign empty = (cnt_q == '0);
  assign full = (cnt_q == DEPTH[AW:0]);
  assign head = ent_q[rd_q];
  // Tail may merge unless it is the head, on the bus or about to launch
  assign merge_ok = !empty && (ent_q[tail].line == in_ent.line)
                    && !((cnt_q == 1) && head_busy);

  //////////////////////////////////////////////////////////////////
  // Pointers: strict ring order, head leaves first
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  //////////////////////////////////////////////////////////////////
  // Data: new entry at tail, or OR-in of store-multiple lanes
  always_ff @(posedge sys_clk)
  begin
    if (push)
      ent_q[wr_q] <= in_ent;
    else if (merge)
    begin
      ent_q[tail].data <= (ent_q[tail].data & ~lane_mask(in_ent.be))
                          | (in_ent.data & lane_mask(in_ent.be));
      ent_q[tail].be <= ent_q[tail].be | in_ent.be;
    end
  end

  // Never written beyond capacity
  no_overflow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push |-> !full) else $error("push into full queue");
endmodule // spb_wq

// ---- rtl/spb_top.sv ----
// Store posting, prefetch buffer, memory port and APB registers
`timescale 1ns/100ps
`include "spb_regs.svh"
module spb_top
  import spb_pkg::*;
#(
  parameter int WQ_DEPTH = `SPB_WQ_DEPTH
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic st_valid,
  input wire logic [31:0] st_addr,
  input wire logic [127:0] st_data,
  input wire logic [15:0] st_be,
  input wire logic st_hit,
  input wire logic st_buf,
  input wire logic st_multi,
  input wire logic st_copyback,
  output logic st_stall,
  input wire logic ld_valid,
  input wire logic [31:0] ld_addr,
  output logic ld_stall,
  output logic ld_hit,
  output logic [31:0] ld_data,
  output logic ld_abort,
  output logic xl_req,
  output logic [31:0] xl_vaddr,
  input wire logic xl_done,
  input wire logic xl_fault,
  input wire logic [31:0] xl_paddr,
  output logic alloc_stall,
  output logic alloc_abort,
  output spb_mem_req_t mem_req,
  output logic mem_valid,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_abort
);
  localparam int AW = $clog2(WQ_DEPTH);
  localparam logic [31:0] CTRL_RST = `SPB_CTRL_RST; // Control reset word

  // Word mask covered by an allocation
  function automatic logic [7:0] spb_wmask(spb_size_t sz, logic [2:0] w);
    case (sz)
      SZ_WORD: spb_wmask = 8'h01 << w;
      SZ_HALF: spb_wmask = w[2] ? 8'hF0 : 8'h0F;
      default: spb_wmask = 8'hFF;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////
  // State
  logic wq_en_q; // Queue enable from control
  logic sync_q; // Unbuffered store pushed, waiting completion
  spb_pf_st_t pf_q; // Allocation sequencer
  spb_mem_st_t mst_q; // Memory port sequencer
  logic [31:0] aadr_q; // Allocation virtual address
  logic [1:0] aent_q; // Target entry
  spb_size_t asz_q; // Allocation size
  logic [26:0] pa_q; // Physical line of the fill
  logic [2:0] fw_q, fl_q; // Current and last fill word
  logic [26:0] tag_q [4]; // Virtual line per entry
  logic [7:0] vld_q [4]; // Valid words per entry
  logic [31:0] dat_q [4][8]; // Buffered words
  logic [3:0] abt_q; // Fill saw an abort
  logic [3:0] fill_q; // Fill in progress
  logic [31:0] prdata_q;

  //////////////////////////////////////////////////////////////////
  // Queue instance and store classification
  spb_wq_ent_t in_ent, head;
  logic wq_full, wq_empty, merge_ok, push, merge, pop, wq_idle;
  logic post, sync, post_take;
  logic [AW:0] wq_cnt;

  assign in_ent = '{line: st_addr[31:4], data: st_data, be: st_be};
  // Hits finish in the cache; the queue never sees them
  assign post = st_valid && !st_hit
                && ((wq_en_q && st_buf) || st_copyback);
  assign sync = st_valid && !st_hit && !post;
  assign merge = post && st_multi && merge_ok;
  assign post_take = post && !merge && !wq_full;
  assign push = post_take || (sync && !sync_q && wq_idle);
  assign pop = (mst_q == M_WR) && mem_ack;
  assign wq_idle = wq_empty && (mst_q != M_WR);

  // Core waits on full queue or on an unbuffered write in flight
  always_comb
  begin
    st_stall = 1'b0;
    if (post && !merge && wq_full)
      st_stall = 1'b1;
    else if (sync && !(sync_q && wq_idle))
      st_stall = 1'b1;
  end

  spb_wq #(.DEPTH(WQ_DEPTH)) u_wq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .push(push),
    .merge(merge),
    .in_ent(in_ent),
    .pop(pop),
    .head_busy(mst_q != M_RD),
    .merge_ok(merge_ok),
    .full(wq_full),
    .empty(wq_empty),
    .count(wq_cnt),
    .head(head)
  );

  // Unbuffered store: push once queue is idle, release once idle again
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      sync_q <= 1'b0;
    else if (sync && !sync_q && wq_idle)
      sync_q <= 1'b1;
    else if (sync_q && wq_idle)
      sync_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////
  // APB decode
  logic acc, wr_acc, is_acmd, is_drn, mapped;
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign is_acmd = (paddr == `SPB_ACMD_OFF);
  assign is_drn = (paddr == `SPB_DRN_OFF);
  assign mapped = (paddr == `SPB_CTRL_OFF) || (paddr == `SPB_STAT_OFF)
                  || (paddr == `SPB_AADR_OFF) || is_acmd
                  || (paddr == `SPB_INVL_OFF) || is_drn;

  // Allocation write holds until translation ends; drain until idle
  always_comb
  begin
    pready = 1'b1;
    if (pwrite && is_acmd)
      pready = (pf_q == P_XL) && xl_done;
    else if (pwrite && is_drn)
      pready = wq_idle;
  end
  assign pslverr = acc && !mapped;
  assign prdata = prdata_q;

  // Read data sampled in the setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      prdata_q <= '0;
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= '0;
      case (paddr)
        `SPB_CTRL_OFF: prdata_q[`SPB_WQ_EN_BIT] <= wq_en_q;
        `SPB_STAT_OFF:
        begin
          prdata_q[`SPB_ST_EMPTY_BIT] <= wq_empty;
          prdata_q[`SPB_ST_CNT_LSB +: 4] <= 4'(wq_cnt);
          prdata_q[`SPB_ST_ABT_LSB +: 4] <= abt_q;
          prdata_q[`SPB_ST_BUSY_BIT] <= (pf_q != P_IDLE);
        end
        `SPB_AADR_OFF: prdata_q <= aadr_q;
        default: prdata_q <= '0;
      endcase
    end
  end

  // Control register; disabling leaves queued writes to finish
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      wq_en_q <= CTRL_RST[`SPB_WQ_EN_BIT];
    else if (wr_acc && paddr == `SPB_CTRL_OFF)
      wq_en_q <= pwdata[`SPB_WQ_EN_BIT];
  end

  //////////////////////////////////////////////////////////////////
  // Allocation sequencer: translate, then fill in the background
  logic start;
  logic [7:0] nmask;
  assign start = wr_acc && is_acmd && (pf_q == P_IDLE);
  assign nmask = spb_wmask(asz_q, aadr_q[4:2]);
  assign xl_req = (pf_q == P_XL);
  assign xl_vaddr = aadr_q;
  assign alloc_stall = (pf_q == P_XL);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pf_q <= P_IDLE;
      aadr_q <= '0;
      aent_q <= '0;
      asz_q <= SZ_WORD;
      pa_q <= '0;
      fw_q <= '0;
      fl_q <= '0;
      alloc_abort <= 1'b0;
    end
    else
    begin
      alloc_abort <= 1'b0;
      if (wr_acc && paddr == `SPB_AADR_OFF && pf_q == P_IDLE)
        aadr_q <= pwdata;
      case (pf_q)
        P_IDLE:
          if (start)
          begin
            aent_q <= pwdata[`SPB_ACMD_ENT_LSB +: 2];
            asz_q <= spb_size_t'(pwdata[`SPB_ACMD_SZ_LSB +: 2]);
            pf_q <= P_XL;
          end
        P_XL:
          if (xl_done && xl_fault)
          begin
            alloc_abort <= 1'b1;
            pf_q <= P_IDLE;
          end
          else if (xl_done)
          begin
            pa_q <= xl_paddr[31:5];
            case (asz_q)
              SZ_WORD:
              begin
                fw_q <= aadr_q[4:2];
                fl_q <= aadr_q[4:2];
              end
              SZ_HALF:
              begin
                fw_q <= {aadr_q[4], 2'b00};
                fl_q <= {aadr_q[4], 2'b11};
              end
              default:
              begin
                fw_q <= 3'b000;
                fl_q <= 3'b111;
              end
            endcase
            pf_q <= P_FILL;
          end
        P_FILL:
          if (mst_q == M_RD && mem_ack)
          begin
            fw_q <= fw_q + 1'b1;
            if (fw_q == fl_q)
              pf_q <= P_IDLE;
          end
        default: pf_q <= P_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // Entry state: invalidate, claim, fill words
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int e = 0; e < 4; e++)
      begin
        vld_q[e] <= '0;
        tag_q[e] <= '0;
      end
      abt_q <= '0;
      fill_q <= '0;
    end
    else
    begin
      // Software invalidate first, so a claim or fill word below wins
      if (wr_acc && paddr == `SPB_INVL_OFF)
        for (int e = 0; e < 4; e++)
          if (pwdata[e] && !fill_q[e])
            vld_q[e] <= '0;
      if (pf_q == P_XL && xl_done && !xl_fault)
      begin
        for (int e = 0; e < 4; e++)
          if (tag_q[e] == aadr_q[31:5] && (vld_q[e] & nmask) != '0)
            vld_q[e] <= '0;
        vld_q[aent_q] <= '0;
        tag_q[aent_q] <= aadr_q[31:5];
        abt_q[aent_q] <= 1'b0;
        fill_q[aent_q] <= 1'b1;
      end
      else if (mst_q == M_RD && mem_ack)
      begin
        dat_q[aent_q][fw_q] <= mem_rdata;
        vld_q[aent_q][fw_q] <= 1'b1;
        if (mem_abort)
          abt_q[aent_q] <= 1'b1;
        if (fw_q == fl_q)
          fill_q[aent_q] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Memory port: queued writes first, then fill words
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      mst_q <= M_IDLE;
      mem_valid <= 1'b0;
      mem_req <= '0;
    end
    else
      case (mst_q)
        M_IDLE:
          if (!wq_empty)
          begin
            mem_req <= '{we: 1'b1, addr: {head.line, 4'h0},
                         wdata: head.data, be: head.be};
            mem_valid <= 1'b1;
            mst_q <= M_WR;
          end
          else if (pf_q == P_FILL)
          begin
            mem_req <= '{we: 1'b0, addr: {pa_q, fw_q, 2'b00},
                         wdata: '0, be: 16'h000F};
            mem_valid <= 1'b1;
            mst_q <= M_RD;
          end
        M_WR:
          // An abort beside the ack does not cancel the write
          if (mem_ack)
          begin
            mem_valid <= 1'b0;
            mst_q <= M_IDLE;
          end
        M_RD:
          if (mem_ack)
          begin
            mem_valid <= 1'b0;
            mst_q <= M_IDLE;
          end
        default: mst_q <= M_IDLE;
      endcase
  end

  //////////////////////////////////////////////////////////////////
  // Load lookup; the buffer copy takes priority over the caches
  logic [3:0] hit_e, busy_e;
  logic [1:0] hsel;
  always_comb
  begin
    hsel = '0;
    for (int e = 0; e < 4; e++)
    begin
      busy_e[e] = fill_q[e] && (tag_q[e] == ld_addr[31:5]);
      hit_e[e] = !fill_q[e] && (tag_q[e] == ld_addr[31:5])
                 && vld_q[e][ld_addr[4:2]];
      if (hit_e[e])
        hsel = 2'(e);
    end
  end
  assign ld_stall = ld_valid && (busy_e != '0);

  // Answer one cycle after the request, a word per clock
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      ld_hit <= 1'b0;
      ld_abort <= 1'b0;
      ld_data <= '0;
    end
    else
    begin
      ld_hit <= ld_valid && !ld_stall && (hit_e != '0);
      ld_abort <= ld_valid && !ld_stall && hit_e[hsel] && abt_q[hsel];
      ld_data <= dat_q[hsel][ld_addr[4:2]];
    end
  end

  //////////////////////////////////////////////////////////////////
  // Checks
  stall_full_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (post && !merge && wq_full) |-> st_stall && !push)
    else $error("full queue did not stall");
  post_go_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (post && !wq_full) |-> !st_stall ##1 !wq_empty)
    else $error("bufferable miss not posted");
  hit_bypass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_valid && st_hit) |-> !push && !merge && !st_stall)
    else $error("cache hit touched queue");
  sync_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sync && !wq_idle) |-> st_stall)
    else $error("unbuffered store passed early");
  reset_off_a: assert property (@(posedge sys_clk)
    !$past(rst_n) |-> !wq_en_q && wq_empty)
    else $error("queue not off after reset");
  fault_nop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pf_q == P_XL && xl_done && xl_fault) |=> pf_q == P_IDLE && alloc_abort
    && $stable(fill_q)) else $error("faulting allocation not dropped");
  wr_abort_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mst_q == M_WR && mem_ack && mem_abort) |=> mst_q == M_IDLE
    && wq_cnt == $past(wq_cnt) - 1'b1 + (AW + 1)'($past(push)))
    else $error("posted write aborted");
  fill_stall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ld_valid && busy_e != '0) |-> ld_stall ##1 !ld_hit)
    else $error("load to filling entry served");
endmodule // spb_top

// ---- dv/spb_far_model.sv ----
// Far-side model: memory controller and address translator
`timescale 1ns/100ps
module spb_far_model
  import spb_pkg::*;
#(
  parameter logic [31:0] PAT = 32'h5A5A_0000
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire spb_mem_req_t mem_req,
  input wire logic mem_valid,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic mem_abort,
  input wire logic xl_req,
  input wire logic [31:0] xl_vaddr,
  output logic xl_done,
  output logic xl_fault,
  output logic [31:0] xl_paddr,
  input wire logic [7:0] ack_wait,
  input wire logic [7:0] xl_wait,
  input wire logic xl_bad,
  input wire logic abort_wr,
  input wire logic [31:0] bad_addr
);
  int mcnt; // Cycles the current memory request has waited
  int xcnt; // Cycles the current translation has waited
  logic [31:0] wr_log[$]; // Write addresses in completion order
  ////////////////////////////////////////////////////////////////////////////
  // Memory answers after ack_wait cycles; ack is a single pulse
  always @(posedge sys_clk)
  begin
    if (!rst_n || mem_ack)
    begin
      mem_ack <= 1'b0;
      mcnt <= 0;
    end
    else if (mem_valid)
    begin
      mcnt <= mcnt + 1;
      if (mcnt >= ack_wait)
        mem_ack <= 1'b1;
    end
  end
  // Log every completed write so order and count can be judged
  always @(posedge sys_clk)
  begin
    if (mem_valid && mem_ack && mem_req.we)
      wr_log.push_back(mem_req.addr);
  end
  // Data is only valid with ack; otherwise the inverse, so stale reads show up
  assign mem_rdata = mem_ack ? (mem_req.addr ^ PAT) : ~(mem_req.addr ^ PAT);
  // Aborts on one chosen read word, and on writes when commanded
  assign mem_abort = mem_ack && (mem_req.we ? abort_wr : mem_req.addr == bad_addr);
  ////////////////////////////////////////////////////////////////////////////
  // Translator finishes after xl_wait cycles, flat mapping
  always @(posedge sys_clk)
  begin
    if (!rst_n || xl_done)
    begin
      xl_done <= 1'b0;
      xcnt <= 0;
    end
    else if (xl_req)
    begin
      xcnt <= xcnt + 1;
      if (xcnt >= xl_wait)
        xl_done <= 1'b1;
    end
  end
  assign xl_fault = xl_done & xl_bad;
  assign xl_paddr = xl_done ? xl_vaddr : ~xl_vaddr;
endmodule // spb_far_model

// ---- dv/spb_top_bench.sv ----
// Self-checking bench for the store and prefetch buffers
`timescale 1ns/100ps
`include "spb_regs.svh"
module spb_top_bench;
  import spb_pkg::*;
  localparam logic [31:0] PAT = 32'h5A5A_0000; // Memory data pattern
  localparam logic [31:0] P = 32'h4000_0000; // Prefetch test region
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st_addr, ld_addr, ld_data, xl_vaddr, xl_paddr, mem_rdata;
  logic st_valid, st_hit, st_buf, st_multi, st_copyback, st_stall;
  logic [127:0] st_data;
  logic [15:0] st_be;
  logic ld_valid, ld_stall, ld_hit, ld_abort, xl_req, xl_done, xl_fault;
  logic alloc_stall, alloc_abort, mem_valid, mem_ack, mem_abort;
  spb_mem_req_t mem_req;
  logic [7:0] ack_wait, xl_wait; // Far-side latencies
  logic xl_bad, abort_wr;
  logic [31:0] bad_addr;
  int mismatches = 0;
  int comparisons = 0;
  int aborts = 0; // Allocation abort pulses seen
  int w, n;
  logic [31:0] d;
  logic e;
  ////////////////////////////////////////////////////////////////////////////
  spb_top i_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .st_valid, .st_addr, .st_data, .st_be, .st_hit, .st_buf, .st_multi,
    .st_copyback, .st_stall, .ld_valid, .ld_addr, .ld_stall, .ld_hit, .ld_data, .ld_abort,
    .xl_req, .xl_vaddr, .xl_done, .xl_fault, .xl_paddr, .alloc_stall, .alloc_abort,
    .mem_req, .mem_valid, .mem_ack, .mem_rdata, .mem_abort);
  spb_far_model #(.PAT(PAT)) i_far (.sys_clk, .rst_n, .mem_req, .mem_valid, .mem_ack,
    .mem_rdata, .mem_abort, .xl_req, .xl_vaddr, .xl_done, .xl_fault, .xl_paddr,
    .ack_wait, .xl_wait, .xl_bad, .abort_wr, .bad_addr);
  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Count allocation abort pulses
  always @(posedge sys_clk)
  begin
    if (alloc_abort === 1'b1)
      aborts++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, wd, x, y);
  endtask
  // One store held until taken; returns stalled cycles
  task automatic st(input logic [31:0] a, input logic h, b, m, c, output int sw);
    @(posedge sys_clk);
    st_valid <= 1'b1;
    st_addr <= a;
    st_data <= {4{a}};
    st_be <= 16'hFFFF;
    st_hit <= h;
    st_buf <= b;
    st_multi <= m;
    st_copyback <= c;
    sw = 0;
    @(posedge sys_clk);
    while (st_stall !== 1'b0)
    begin
      @(posedge sys_clk);
      sw++;
    end
    st_valid <= 1'b0;
  endtask
  // One load; returns stalled cycles, results settle after the taking edge
  task automatic ld(input logic [31:0] a, output int lw);
    @(posedge sys_clk);
    ld_valid <= 1'b1;
    ld_addr <= a;
    lw = 0;
    @(posedge sys_clk);
    while (ld_stall !== 1'b0)
    begin
      @(posedge sys_clk);
      lw++;
    end
    ld_valid <= 1'b0;
    #1;
  endtask
  task automatic ldchk(input logic [31:0] a, input logic hit, input logic abt);
    int lw;
    ld(a, lw);
    chk("ld_hit", ld_hit, hit);
    chk("ld_abort", ld_abort, abt);
    if (hit)
      chk("ld_data", ld_data, (a & 32'hFFFF_FFFC) ^ PAT);
  endtask
  task automatic alloc(input logic [31:0] a, input logic [1:0] ent, input spb_size_t sz);
    wr(`SPB_AADR_OFF, a);
    wr(`SPB_ACMD_OFF, (32'(sz) << `SPB_ACMD_SZ_LSB) | 32'(ent));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped address
  task automatic t_reset;
    apb(1'b0, `SPB_CTRL_OFF, 0, d, e);
    chk("ctrl", d, `SPB_CTRL_RST);
    apb(1'b0, `SPB_STAT_OFF, 0, d, e);
    chk("stat", d, 32'h0000_0001);
    apb(1'b0, 8'h18, 0, d, e);
    chk("pslverr", e, 1'b1);
    chk("unmapped", d, 32'h0000_0000);
  endtask
  // Cache hit with the queue enabled leaves memory alone
  task automatic t_hit;
    wr(`SPB_CTRL_OFF, 32'h1 << `SPB_WQ_EN_BIT);
    n = i_far.wr_log.size();
    st(32'h1000_0000, 1'b1, 1'b1, 1'b0, 1'b0, w);
    chk("hit stall", w, 0);
    repeat (40) @(posedge sys_clk);
    chk("hit writes", i_far.wr_log.size(), n);
  endtask
  // Nine posts against a slow memory that aborts writes
  task automatic t_queue;
    ack_wait = 8'd30;
    abort_wr = 1'b1;
    n = i_far.wr_log.size();
    for (int i = 0; i < 9; i++)
    begin
      st(32'h2000_0000 + i * 16, 1'b0, 1'b1, 1'b0, 1'b0, w);
      if (i < 8)
        chk("post stall", w, 0);
      else
        chk("full stall", w > 0, 1'b1);
    end
    apb(1'b0, `SPB_STAT_OFF, 0, d, e);
    chk("stat count", d, 32'h8 << `SPB_ST_CNT_LSB);
    wr(`SPB_DRN_OFF, 0);
    chk("writes", i_far.wr_log.size(), n + 9);
    for (int i = 0; i < 9; i++)
      chk("order", i_far.wr_log[n + i], 32'h2000_0000 + i * 16);
    abort_wr = 1'b0;
  endtask
  // Only store-multiple words merge into the tail
  task automatic t_merge;
    n = i_far.wr_log.size();
    st(32'h3000_0000, 1'b0, 1'b1, 1'b0, 1'b0, w);
    st(32'h3000_0040, 1'b0, 1'b1, 1'b0, 1'b0, w);
    st(32'h3000_0044, 1'b0, 1'b1, 1'b1, 1'b0, w);
    st(32'h3000_0048, 1'b0, 1'b1, 1'b0, 1'b0, w);
    wr(`SPB_DRN_OFF, 0);
    chk("merged writes", i_far.wr_log.size(), n + 3);
  endtask
  // Unbuffered and queue-disabled stores wait for memory; copy-backs keep posting; disable keeps queued writes
  task automatic t_unbuf;
    ack_wait = 8'd10;
    n = i_far.wr_log.size();
    st(32'h5000_0000, 1'b0, 1'b0, 1'b0, 1'b0, w);
    chk("unbuf wait", w >= 10, 1'b1);
    chk("unbuf done", i_far.wr_log.size(), n + 1);
    wr(`SPB_CTRL_OFF, 0);
    st(32'h5000_0010, 1'b0, 1'b1, 1'b0, 1'b0, w);
    chk("disabled wait", w >= 10, 1'b1);
    st(32'h5000_0020, 1'b0, 1'b0, 1'b0, 1'b1, w);
    chk("copyback stall", w, 0);
    wr(`SPB_CTRL_OFF, 32'h1 << `SPB_WQ_EN_BIT);
    st(32'h5000_0030, 1'b0, 1'b1, 1'b0, 1'b0, w);
    st(32'h5000_0040, 1'b0, 1'b1, 1'b0, 1'b0, w);
    wr(`SPB_CTRL_OFF, 0);
    wr(`SPB_DRN_OFF, 0);
    chk("drained", i_far.wr_log.size(), n + 5);
  endtask
  // Prefetch allocations, stalls, invalidation and aborts
  task automatic t_pref;
    ack_wait = 8'd2;
    wr(`SPB_INVL_OFF, 32'h0000_000F);
    alloc(P + 32'h14, 2'd0, SZ_LINE);
    ld(P + 32'h4, w);
    chk("fill stall", w > 0, 1'b1);
    ldchk(P + 32'h1C, 1'b1, 1'b0);
    ldchk(P + 32'h0, 1'b1, 1'b0);
    alloc(P + 32'h4C, 2'd1, SZ_HALF);
    ldchk(P + 32'h40, 1'b1, 1'b0);
    ldchk(P + 32'h50, 1'b0, 1'b0);
    alloc(P + 32'h88, 2'd2, SZ_WORD);
    ldchk(P + 32'h88, 1'b1, 1'b0);
    ldchk(P + 32'h8C, 1'b0, 1'b0);
    alloc(P + 32'h4, 2'd3, SZ_WORD);
    ldchk(P + 32'h4, 1'b1, 1'b0);
    ldchk(P + 32'h8, 1'b0, 1'b0);
    alloc(P + 32'h200, 2'd1, SZ_WORD);
    ldchk(P + 32'h200, 1'b1, 1'b0);
    ldchk(P + 32'h40, 1'b0, 1'b0);
    xl_bad <= 1'b1;
    n = aborts;
    alloc(P + 32'h300, 2'd0, SZ_WORD);
    xl_bad <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("alloc abort", aborts, n + 1);
    ldchk(P + 32'h300, 1'b0, 1'b0);
    bad_addr = P + 32'h400;
    alloc(P + 32'h400, 2'd2, SZ_WORD);
    ldchk(P + 32'h400, 1'b1, 1'b1);
    wr(`SPB_CTRL_OFF, 32'h1 << `SPB_WQ_EN_BIT);
    st(P + 32'h200, 1'b0, 1'b1, 1'b0, 1'b0, w);
    wr(`SPB_DRN_OFF, 0);
    ldchk(P + 32'h200, 1'b1, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Main sequence: every input defined at time zero, reset for two cycles
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {st_valid, st_addr, st_data, st_be, st_hit, st_buf, st_multi, st_copyback} = '0;
    {ld_valid, ld_addr, xl_bad, abort_wr} = '0;
    ack_wait = 8'd1;
    xl_wait = 8'd3;
    bad_addr = 32'hFFFF_FFFC;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_hit();
    t_queue();
    t_merge();
    t_unbuf();
    t_pref();
    stop_test();
  end
  // Watchdog: the whole run needs about a thousand cycles
  initial
  begin
    #500000;
    mismatches++;
    stop_test();
  end
endmodule // spb_top_bench
